/* core/osc_switch_ctrl.sv */
/*
  oscillator select, clock divider and pll feedback registers behind an
  axi4-lite slave, with switch tracking, fail flag and doze control.
  assumes switch_done_i, interrupt_i and the strap inputs are on clock_i;
  fail_detect_i and pll_lock_i are asynchronous and get synchronised.
*/
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module osc_switch_ctrl (
  input  wire logic                             clock_i,
  input  wire logic                             rst_n_i,
  input  wire logic [31:0]                      awaddr_i,
  input  wire logic                             awvalid_i,
  output logic                                  awready_o,
  input  wire logic [31:0]                      wdata_i,
  input  wire logic [3:0]                       wstrb_i,
  input  wire logic                             wvalid_i,
  output logic                                  wready_o,
  output logic [1:0]                            bresp_o,
  output logic                                  bvalid_o,
  input  wire logic                             bready_i,
  input  wire logic [31:0]                      araddr_i,
  input  wire logic                             arvalid_i,
  output logic                                  arready_o,
  output logic [31:0]                           rdata_o,
  output logic [1:0]                            rresp_o,
  output logic                                  rvalid_o,
  input  wire logic                             rready_i,
  input  wire logic [osc_ctrl_pkg::SEL_W-1:0]   config_new_source_i,
  input  wire logic                             monitor_config_bit_zero_i,
  input  wire logic                             fail_detect_i,
  input  wire logic                             pll_lock_i,
  input  wire logic                             interrupt_i,
  input  wire logic                             switch_done_i,
  output logic [osc_ctrl_pkg::SEL_W-1:0]        current_source_o,
  output logic [osc_ctrl_pkg::SEL_W-1:0]        switch_target_o,
  output logic                                  switch_pending_o,
  output logic                                  osc_fail_trap_o,
  output logic [7:0]                            doze_factor_o,
  output logic [8:0]                            fast_rc_factor_o,
  output logic [3:0]                            pll_prescaler_o,
  output logic [7:0]                            pll_feedback_o
);
  import osc_ctrl_pkg::*;

  typedef struct packed {
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [2:0]  current_source_sel;
    logic [2:0]  new_source_sel;
    logic [2:0]  target;
    logic        switch_request;
    logic        config_freeze;
    logic        clock_fail_flag;
    logic        pll_settled;
    logic        trap;
    logic        recover_on_interrupt;
    logic [2:0]  ratio;
    logic        reduction_enable;
    logic [7:0]  doze_factor;
    logic [2:0]  fast_rc_postscaler;
    logic [8:0]  frc_factor;
    logic [3:0]  pll_prescaler;
    logic [7:0]  pll_feedback_value;
  } ctrl_state_type;

  ctrl_state_type st_q;
  ctrl_state_type st_d;
  ctrl_state_type st_rst;

  logic       fail_sync;
  logic       lock_sync;
  logic       hi_armed;
  logic       lo_armed;
  logic       wr_fire;
  logic       wr_osc;
  logic       wr_div;
  logic       wr_fbd;
  logic       frozen;
  logic [31:0] rd_osc;
  logic [31:0] rd_div;
  logic [31:0] rd_fbd;

  // asynchronous status inputs
  bit_synchronizer #(
    .WIDTH (2)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({fail_detect_i, pll_lock_i}),
    .sync_o  ({fail_sync, lock_sync})
  );

  // write decode, one executed write per response
  assign wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;
  assign wr_osc  = wr_fire && (st_q.aw_addr == OSC_SEL_OFF);
  assign wr_div  = wr_fire && (st_q.aw_addr == CLK_DIV_OFF);
  assign wr_fbd  = wr_fire && (st_q.aw_addr == PLL_FBD_OFF);
  assign frozen  = st_q.config_freeze && monitor_config_bit_zero_i; // see RQ6

  // upper byte lane unlock
  unlock_sequencer #(
    .KEY_FIRST  (KEY_HI_FIRST),
    .KEY_SECOND (KEY_HI_SECOND)
  ) u_unlock_hi (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .write_fire_i (wr_fire),
    .lane_en_i    (wr_osc && st_q.w_strb[1]),
    .lane_data_i  (st_q.w_data[15:8]),
    .armed_o      (hi_armed)
  );

  // lower byte lane unlock
  unlock_sequencer #(
    .KEY_FIRST  (KEY_LO_FIRST),
    .KEY_SECOND (KEY_LO_SECOND)
  ) u_unlock_lo (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .write_fire_i (wr_fire),
    .lane_en_i    (wr_osc && st_q.w_strb[0]),
    .lane_data_i  (st_q.w_data[7:0]),
    .armed_o      (lo_armed)
  );

  // read images, unimplemented bits zero
  always_comb begin
    rd_osc = 32'h00000000; // see RQ22
    rd_osc[CUR_POS +: 3]   = st_q.current_source_sel; // see RQ1
    rd_osc[NEW_POS +: 3]   = st_q.new_source_sel;
    rd_osc[FREEZE_POS]     = st_q.config_freeze;
    rd_osc[SETTLED_POS]    = st_q.pll_settled;
    rd_osc[FAIL_POS]       = st_q.clock_fail_flag;
    rd_osc[SWITCH_POS]     = st_q.switch_request;
    rd_div = 32'h00000000;
    rd_div[ROI_POS]        = st_q.recover_on_interrupt;
    rd_div[RATIO_POS +: 3] = st_q.ratio;
    rd_div[REDUCTION_ENABLE_POS]      = st_q.reduction_enable;
    rd_div[FAST_RC_POSTSCALER_POS +: 3] = st_q.fast_rc_postscaler;
    rd_div[PLL_PRESCALER_POS +: 4] = st_q.pll_prescaler;
    rd_fbd = 32'h00000000;
    rd_fbd[FBD_POS +: 8]   = st_q.pll_feedback_value;
  end

  // next state of bus slave and control registers
  always_comb begin
    st_rst = '0;
    st_rst.awready            = 1'b1;
    st_rst.wready             = 1'b1;
    st_rst.arready            = 1'b1;
    st_rst.current_source_sel = map_source(config_new_source_i);
    st_rst.new_source_sel     = config_new_source_i; // see RQ2
    st_rst.target             = map_source(config_new_source_i);
    st_rst.ratio              = RATIO_RST; // see RQ14
    st_rst.doze_factor        = 8'h01;
    st_rst.fast_rc_postscaler = FAST_RC_POSTSCALER_RST;
    st_rst.frc_factor         = frc_factor(FAST_RC_POSTSCALER_RST);
    st_rst.pll_prescaler      = PLL_PRESCALER_RST; // see RQ19
    st_rst.pll_feedback_value = FBD_RST; // see RQ21

    st_d = st_q;
    // address and data channels, either order
    if (awvalid_i && st_q.awready) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = awaddr_i;
    end
    if (wvalid_i && st_q.wready) begin
      st_d.w_held = 1'b1;
      st_d.w_data = wdata_i;
      st_d.w_strb = wstrb_i;
    end
    if (st_q.bvalid && bready_i) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (wr_osc || wr_div || wr_fbd) ? RESP_OKAY : RESP_SLVERR;
    end

    // read channel
    if (st_q.rvalid && rready_i) begin
      st_d.rvalid = 1'b0;
    end
    if (arvalid_i && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      if (araddr_i == OSC_SEL_OFF) begin
        st_d.rdata = rd_osc;
      end else if (araddr_i == CLK_DIV_OFF) begin
        st_d.rdata = rd_div;
      end else if (araddr_i == PLL_FBD_OFF) begin
        st_d.rdata = rd_fbd;
      end else begin
        st_d.rdata = 32'h00000000;
        st_d.rresp = RESP_SLVERR;
      end
    end

    // switch completion copies mapped selection
    if (st_q.switch_request && switch_done_i) begin
      st_d.current_source_sel = st_q.target; // see RQ23
      st_d.switch_request     = 1'b0; // see RQ4
    end

    // upper byte only right after its keys
    if (wr_osc && st_q.w_strb[1] && hi_armed && !frozen) begin
      st_d.new_source_sel = st_q.w_data[NEW_POS +: 3]; // see RQ10
    end
    // lower byte only right after its keys
    if (wr_osc && st_q.w_strb[0] && lo_armed) begin
      if (!frozen && st_q.w_data[SWITCH_POS]) begin
        st_d.switch_request = 1'b1; // see RQ4
      end
      if (st_q.w_data[FREEZE_POS]) begin
        st_d.config_freeze = 1'b1;
      end else if (!frozen) begin
        st_d.config_freeze = 1'b0;
      end
      st_d.clock_fail_flag = st_q.w_data[FAIL_POS]; // see RQ8
    end
    // monitor detection beats a software clear
    if (fail_sync) begin
      st_d.clock_fail_flag = 1'b1; // see RQ8
    end
    st_d.trap = st_d.clock_fail_flag && !st_q.clock_fail_flag; // see RQ24
    if (st_d.trap) begin
      st_d.current_source_sel = SRC_BACKUP_RC;
      st_d.switch_request     = 1'b0;
    end
    st_d.target      = map_source(st_d.new_source_sel); // see RQ3
    st_d.pll_settled = lock_sync; // see RQ7

    // clock divider register, no unlock needed
    if (wr_div && st_q.w_strb[1]) begin
      st_d.recover_on_interrupt = st_q.w_data[ROI_POS];
      if (!st_q.reduction_enable) begin
        st_d.ratio = st_q.w_data[RATIO_POS +: 3]; // see RQ16
      end
      st_d.reduction_enable = st_q.w_data[REDUCTION_ENABLE_POS] && (st_d.ratio != 3'h0); // see RQ17
      if (!frozen) begin
        st_d.fast_rc_postscaler = st_q.w_data[FAST_RC_POSTSCALER_POS +: 3];
      end
    end
    if (wr_div && st_q.w_strb[0] && !frozen) begin
      st_d.pll_prescaler = st_q.w_data[PLL_PRESCALER_POS +: 4]; // see RQ20
    end
    if (interrupt_i && st_q.recover_on_interrupt) begin
      st_d.reduction_enable = 1'b0; // see RQ13
    end
    st_d.doze_factor = st_d.reduction_enable ? 8'(8'h01 << st_d.ratio) : 8'h01; // see RQ15
    st_d.frc_factor  = frc_factor(st_d.fast_rc_postscaler); // see RQ18

    // feedback divider stored as written
    if (wr_fbd && st_q.w_strb[0] && !frozen) begin
      st_d.pll_feedback_value = st_q.w_data[FBD_POS +: 8];
    end

    st_d.awready = !st_d.aw_held && !st_d.bvalid;
    st_d.wready  = !st_d.w_held && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_q <= st_rst;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign awready_o        = st_q.awready;
  assign wready_o         = st_q.wready;
  assign bvalid_o         = st_q.bvalid;
  assign bresp_o          = st_q.bresp;
  assign arready_o        = st_q.arready;
  assign rvalid_o         = st_q.rvalid;
  assign rresp_o          = st_q.rresp;
  assign rdata_o          = st_q.rdata;
  assign current_source_o = st_q.current_source_sel;
  assign switch_target_o  = st_q.target;
  assign switch_pending_o = st_q.switch_request;
  assign osc_fail_trap_o  = st_q.trap;
  assign doze_factor_o    = st_q.doze_factor;
  assign fast_rc_factor_o = st_q.frc_factor;
  assign pll_prescaler_o  = st_q.pll_prescaler;
  assign pll_feedback_o   = st_q.pll_feedback_value;

  // checks on the control behaviour
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_trap_follows_flag: assert property ($rose(st_q.clock_fail_flag) |-> osc_fail_trap_o ##1 !osc_fail_trap_o) // see RQ24
    else $error("trap did not pulse with fail flag");
  a_trap_has_cause: assert property (osc_fail_trap_o |-> !$past(st_q.clock_fail_flag)) // see RQ8
    else $error("trap without fail flag rise");
  a_ratio_held: assert property ($past(st_q.reduction_enable) |-> st_q.ratio == $past(st_q.ratio)) // see RQ16
    else $error("ratio changed while reduction enabled");
  a_enable_nonzero: assert property (st_q.reduction_enable |-> st_q.ratio != 3'h0) // see RQ17
    else $error("reduction enabled with zero ratio");
  a_recover_clears: assert property (interrupt_i && st_q.recover_on_interrupt |=> !st_q.reduction_enable
                                     ##0 doze_factor_o == 8'h01) // see RQ13
    else $error("interrupt did not restore 1:1");
  a_switch_completes: assert property (st_q.switch_request && switch_done_i && !fail_sync
                                       && !st_q.clock_fail_flag && !wr_osc |=> !switch_pending_o
                                       && current_source_o == $past(st_q.target)) // see RQ23
    else $error("switch completion not reflected");
  a_reserved_fallback: assert property (st_q.new_source_sel == SRC_RESERVED |=> switch_target_o == SRC_FAST_RC
                                        || $past(st_q.new_source_sel) != st_q.new_source_sel) // see RQ3
    else $error("reserved code not mapped to fast rc");
  a_locked_select: assert property (wr_osc && !hi_armed |=> $stable(st_q.new_source_sel)) // see RQ11
    else $error("selection changed without unlock");
  a_freeze_holds: assert property (frozen && monitor_config_bit_zero_i ##1 monitor_config_bit_zero_i
                                   |-> $stable(st_q.pll_feedback_value) && $stable(st_q.pll_prescaler)) // see RQ6
    else $error("pll settings changed while frozen");
  a_settled_tracks: assert property (pll_lock_i [*4] |-> st_q.pll_settled) // see RQ7
    else $error("settled bit did not follow lock");
  a_bvalid_holds: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped early");

  // flag and switch request set paths
  a_monitor_sets_flag: assert property (fail_sync |=> st_q.clock_fail_flag) // see RQ8
    else $error("monitor detection did not set fail flag");
  a_request_sets: assert property (wr_osc && lo_armed && !frozen && !st_d.trap // see RQ4
                                   && st_q.w_strb[0] && st_q.w_data[SWITCH_POS] |=> switch_pending_o)
    else $error("unlocked switch write did not set pending");

  c_switch_done: cover property (switch_pending_o ##[1:20] !switch_pending_o);
  c_doze_active: cover property (st_q.reduction_enable && doze_factor_o != 8'h01);
  c_trap_pulse: cover property (osc_fail_trap_o);
  c_unlocked_write: cover property (wr_osc && hi_armed);

endmodule : osc_switch_ctrl

/* core/osc_ctrl_pkg.sv */
/*
  constants, field layout, reset values and source encodings shared by the
  oscillator control block and its helpers.
  assumes a 32-bit axi4-lite register bus and one 40 mhz system clock.
*/
// Overview of operation
// RQ1 - current source field reports active oscillator
// RQ2 - new source field writable, reset from strap
// RQ3 - reserved source code falls back to fast rc
// RQ4 - switch request set by write, cleared on completion
// RQ5 - software avoids direct pll to pll switches
// RQ6 - freeze plus monitor bit blocks clock settings
// RQ7 - pll settled bit follows lock input
// RQ8 - fail flag set by monitor or software
// RQ9 - software only clears fail flag normally
// RQ10 - control register writes need unlock sequence
// RQ11 - upper byte keys 0x78 then 0x9a
// RQ12 - lower byte keys 0x46 then 0x57
// RQ13 - interrupt clears reduction enable when recovering
// RQ14 - reduction ratio divides by two power code
// RQ15 - reduction enable selects ratio, else 1:1
// RQ16 - ratio writes ignored while reduction enabled
// RQ17 - reduction enable cannot set with ratio zero
// RQ18 - fast rc postscaler divide table
// RQ19 - pll prescaler divides by code, reset one
// RQ20 - pll prescaler writable while pll runs
// RQ21 - feedback divider resets to 150
// RQ22 - unimplemented bits read zero, writes ignored
// RQ23 - completion copies selection, clears request together
// RQ24 - trap output pulses when fail flag sets
package osc_ctrl_pkg;

  // register byte addresses
  localparam logic [31:0] OSC_SEL_OFF  = 32'h00000000;
  localparam logic [31:0] CLK_DIV_OFF  = 32'h00000004;
  localparam logic [31:0] PLL_FBD_OFF  = 32'h00000008;

  localparam int SEL_W = 3;

  // oscillator select control fields
  localparam int CUR_POS     = 12;
  localparam int NEW_POS     = 8;
  localparam int FREEZE_POS  = 7;
  localparam int SETTLED_POS = 5;
  localparam int FAIL_POS    = 3;
  localparam int SWITCH_POS  = 0;

  // clock divider and pll feedback control fields
  localparam int ROI_POS    = 15;
  localparam int RATIO_POS  = 12;
  localparam int REDUCTION_ENABLE_POS  = 11;
  localparam int FAST_RC_POSTSCALER_POS = 8;
  localparam int PLL_PRESCALER_POS = 0;
  localparam int FBD_POS    = 0;

  // reset values
  localparam logic [2:0] RATIO_RST  = 3'h3;
  localparam logic [2:0] FAST_RC_POSTSCALER_RST = 3'h0;
  localparam logic [3:0] PLL_PRESCALER_RST = 4'h1;
  localparam logic [7:0] FBD_RST    = 8'h96;

  // unlock keys per byte lane
  localparam logic [7:0] KEY_HI_FIRST  = 8'h78;
  localparam logic [7:0] KEY_HI_SECOND = 8'h9a;
  localparam logic [7:0] KEY_LO_FIRST  = 8'h46;
  localparam logic [7:0] KEY_LO_SECOND = 8'h57;

  // source encodings
  localparam logic [2:0] SRC_FAST_RC     = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY     = 3'h2;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_RESERVED    = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER   = 3'h5;
  localparam logic [2:0] SRC_BACKUP_RC   = 3'h6;
  localparam logic [2:0] SRC_DIV_FAST_RC = 3'h7;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reserved code lands on fast rc
  function automatic logic [2:0] map_source(input logic [2:0] code);
    map_source = (code == SRC_RESERVED) ? SRC_FAST_RC : code; // see RQ3
  endfunction : map_source

  // fast rc postscaler factor
  function automatic logic [8:0] frc_factor(input logic [2:0] code);
    case (code)
      3'h0: frc_factor = 9'h001;
      3'h1: frc_factor = 9'h002;
      3'h2: frc_factor = 9'h004;
      3'h3: frc_factor = 9'h008;
      3'h4: frc_factor = 9'h010;
      3'h5: frc_factor = 9'h020;
      3'h6: frc_factor = 9'h040;
      default: frc_factor = 9'h100;
    endcase
  endfunction : frc_factor

endpackage : osc_ctrl_pkg

/* core/bit_synchronizer.sv */
/*
  two flip-flop synchroniser for asynchronous level inputs.
  assumes the inputs are levels that stay for several clock cycles.
*/
`timescale 1ns/1ps
module bit_synchronizer #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type st_q;
  sync_state_type st_d;

  // first stage feeds only the second
  always_comb begin
    st_d        = st_q;
    st_d.first  = async_i;
    st_d.second = st_q.first;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.second;

endmodule : bit_synchronizer

/* core/unlock_sequencer.sv */
/*
  two-key unlock tracker for one byte lane of a protected register.
  assumes one pulse on write_fire_i per executed bus write.
*/
`timescale 1ns/1ps
module unlock_sequencer #(
  parameter logic [7:0] KEY_FIRST  = 8'h00,
  parameter logic [7:0] KEY_SECOND = 8'h00
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       write_fire_i,
  input  wire logic       lane_en_i,
  input  wire logic [7:0] lane_data_i,
  output logic            armed_o
);

  typedef enum logic [1:0] {IDLE, GOT_FIRST, ARMED} unlock_state_type;

  typedef struct packed {
    unlock_state_type state;
  } seq_state_type;

  seq_state_type st_q;
  seq_state_type st_d;

  // any write steps the sequence; a foreign write breaks it
  always_comb begin
    st_d = st_q;
    if (write_fire_i) begin
      if (st_q.state == ARMED) begin
        st_d.state = IDLE; // armed for one write only, see RQ11
      end else if (lane_en_i && st_q.state == GOT_FIRST && lane_data_i == KEY_SECOND) begin
        st_d.state = ARMED; // see RQ12
      end else if (lane_en_i && lane_data_i == KEY_FIRST) begin
        st_d.state = GOT_FIRST;
      end else begin
        st_d.state = IDLE;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_q <= '{state: IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  assign armed_o = (st_q.state == ARMED);

endmodule : unlock_sequencer

/* tb/osc_switch_ctrl_test.sv */
/*
  self-checking bench for the oscillator control block over axi4-lite.
  assumes strap 010, monitor bit zero high until the last scenario, inputs on clock_i.
*/
`timescale 1ns/1ps
module osc_switch_ctrl_test;
  import osc_ctrl_pkg::*;
  logic        clock_i = 0, rst_n_i = 0;
  logic [31:0] awaddr_i = 0, wdata_i = 0, araddr_i = 0;
  logic [3:0]  wstrb_i = 0;
  logic        awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0]  bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic [2:0]  current_source_o, switch_target_o;
  logic        switch_pending_o, osc_fail_trap_o;
  logic        pll_lock_i = 0, interrupt_i = 0, switch_done_i = 0;
  logic        fail_detect_i = 0, monitor_config_bit_zero_i = 1;
  logic [7:0]  doze_factor_o, pll_feedback_o;
  logic [8:0]  fast_rc_factor_o;
  logic [3:0]  pll_prescaler_o;
  logic [1:0]  bresp_seen = 0;
  int          failures = 0, samples_checked = 0, cycles = 0, trap_count = 0;

  osc_switch_ctrl dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .config_new_source_i(SRC_PRIMARY), .monitor_config_bit_zero_i(monitor_config_bit_zero_i),
    .fail_detect_i(fail_detect_i),
    .pll_lock_i(pll_lock_i), .interrupt_i(interrupt_i), .switch_done_i(switch_done_i),
    .current_source_o(current_source_o), .switch_target_o(switch_target_o),
    .switch_pending_o(switch_pending_o), .osc_fail_trap_o(osc_fail_trap_o), .doze_factor_o(doze_factor_o),
    .fast_rc_factor_o(fast_rc_factor_o), .pll_prescaler_o(pll_prescaler_o), .pll_feedback_o(pll_feedback_o));

  // clock, hang guard and trap catcher
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (osc_fail_trap_o === 1'b1) trap_count++;
    if (cycles == 6000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one axi write, channels released as each is taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_t, w_t, b_t;
    aw_t = 0; w_t = 0; b_t = 0;
    @(posedge clock_i);
    awaddr_i <= a; wdata_i <= d; wstrb_i <= s;
    awvalid_i <= 1; wvalid_i <= 1; bready_i <= 1;
    while (!b_t) begin
      @(posedge clock_i);
      if (!aw_t && awready_o) begin aw_t = 1; awvalid_i <= 0; end
      if (!w_t && wready_o) begin w_t = 1; wvalid_i <= 0; end
      if (bvalid_o) begin b_t = 1; bresp_seen = bresp_o; bready_i <= 0; end
    end
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_t;
    a_t = 0;
    @(posedge clock_i);
    araddr_i <= a; arvalid_i <= 1; rready_i <= 1;
    forever begin
      @(posedge clock_i);
      if (!a_t && arready_o) begin a_t = 1; arvalid_i <= 0; end
      if (rvalid_o) begin d = rdata_o; r = rresp_o; rready_i <= 0; break; end
    end
  endtask : rd

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, exp);
  endtask : rd_chk

  task automatic reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(OSC_SEL_OFF, 32'h00002200);
    rd_chk(CLK_DIV_OFF, 32'h00003001);
    rd_chk(PLL_FBD_OFF, 32'h00000096);
    check(doze_factor_o, 32'h1);
    rd(32'h0000000c, d, r);
    check(r, RESP_SLVERR);
    wr(32'h0000000c, 32'h00000000, 4'hf);
    check(bresp_seen, RESP_SLVERR);
  endtask : reset_values

  task automatic locked_then_switch();
    wr(OSC_SEL_OFF, 32'h00000401, 4'h3);
    check(bresp_seen, RESP_OKAY);
    rd_chk(OSC_SEL_OFF, 32'h00002200);
    wr(OSC_SEL_OFF, 32'h00007846, 4'h3);
    wr(OSC_SEL_OFF, 32'h00009a57, 4'h3);
    wr(OSC_SEL_OFF, 32'h00000401, 4'h3); // primary to fast rc, no pll to pll step
    rd_chk(OSC_SEL_OFF, 32'h00002401);
    check(switch_pending_o, 32'h1);
    check(switch_target_o, 32'h0);
    @(posedge clock_i) switch_done_i <= 1;
    @(posedge clock_i) switch_done_i <= 0;
    rd_chk(OSC_SEL_OFF, 32'h00000400);
    check(current_source_o, 32'h0);
    check(switch_pending_o, 32'h0);
  endtask : locked_then_switch

  task automatic doze_rules();
    wr(CLK_DIV_OFF, 32'h00000001, 4'h3);
    wr(CLK_DIV_OFF, 32'h00000801, 4'h3);
    rd_chk(CLK_DIV_OFF, 32'h00000001);
    wr(CLK_DIV_OFF, 32'h0000d001, 4'h3);
    wr(CLK_DIV_OFF, 32'h0000d801, 4'h3);
    check(doze_factor_o, 32'h20);
    wr(CLK_DIV_OFF, 32'h0000c801, 4'h3);
    rd_chk(CLK_DIV_OFF, 32'h0000d801);
    @(posedge clock_i) interrupt_i <= 1;
    @(posedge clock_i) interrupt_i <= 0;
    rd_chk(CLK_DIV_OFF, 32'h0000d001);
    check(doze_factor_o, 32'h1);
  endtask : doze_rules

  task automatic dividers();
    logic [8:0] tbl [8] = '{9'h1, 9'h2, 9'h4, 9'h8, 9'h10, 9'h20, 9'h40, 9'h100};
    pll_lock_i <= 1;
    for (int i = 0; i < 8; i++) begin
      wr(CLK_DIV_OFF, {21'h0, i[2:0], 8'h08}, 4'h3);
      check(fast_rc_factor_o, tbl[i]);
    end
    check(pll_prescaler_o, 32'h8);
    wr(PLL_FBD_OFF, 32'hffffff10, 4'hf);
    rd_chk(PLL_FBD_OFF, 32'h00000010);
    rd_chk(OSC_SEL_OFF, 32'h00000420);
  endtask : dividers

  task automatic fail_and_freeze();
    wr(OSC_SEL_OFF, 32'h00000046, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000057, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000008, 4'h1); // emulated failure
    rd_chk(OSC_SEL_OFF, 32'h00006428);
    check(trap_count, 32'h1);
    wr(OSC_SEL_OFF, 32'h00000046, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000057, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000080, 4'h1);
    wr(PLL_FBD_OFF, 32'h00000020, 4'hf);
    check(pll_feedback_o, 32'h10);
  endtask : fail_and_freeze

  // monitor detection, set beats clear, then monitor bit low unfreezes
  task automatic monitor_failure();
    @(posedge clock_i) fail_detect_i <= 1;
    repeat (6) @(posedge clock_i);
    wr(OSC_SEL_OFF, 32'h00000046, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000057, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000080, 4'h1); // clear tried while failing
    rd_chk(OSC_SEL_OFF, 32'h000064a8);
    check(trap_count, 32'h2);
    fail_detect_i <= 0;
    wr(OSC_SEL_OFF, 32'h00000046, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000057, 4'h1);
    wr(OSC_SEL_OFF, 32'h00000080, 4'h1);
    rd_chk(OSC_SEL_OFF, 32'h000064a0);
    monitor_config_bit_zero_i <= 0;
    wr(PLL_FBD_OFF, 32'h00000020, 4'hf);
    check(pll_feedback_o, 32'h20);
  endtask : monitor_failure

  task automatic give_verdict();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1;
    reset_values();
    locked_then_switch();
    doze_rules();
    dividers();
    fail_and_freeze();
    monitor_failure();
    give_verdict();
  end
endmodule : osc_switch_ctrl_test
